// >>> jts_tx.sv
/*
 * Transmit transport, scrambling and framing of a JESD204C lane group:
 * octet mapping, CGS/ILAS/data sequencing, multiframe and multiblock
 * counters, sync headers. Assumes an outside serializer and 8B/10B or
 * 64B/66B line coder take the octets, k flags and headers.
 */
`default_nettype none

// Overview of operation
// - lanes carry 8B/10B or 64B/66B per mode
// - up to sixteen lanes carry the data
// - 64B/66B sync uses headers, not request line
// - one device clock drives all logic
// - SYSREF resets multiframe and multiblock counters
// - FEC optional in 64B/66B modes
// - no 64B/80B, command channel or CRC3
// - subclass 1, usable by subclass 0 receivers
// - lanes of one link share alignment
// - sync pin handshake used in 8B/10B
// - samples from converter or down-converter
// - octets framed by F over L lanes
// - one mode setting fixes all framing parameters
// - mode selects bypass or decimate 4..32
// - multiframes, or blocks and multiblocks
// - scrambling optional 8B/10B, forced 64B/66B
// - scramble octets or blocks before encoding
// - lane alignment sequence never scrambled
// - scramble enable bit, different polynomials
// - boundaries, initialisation, encoding and monitoring
// - two-bit header prefixes each 64-bit block
module jts_tx
	import jts_pkg::*;
#(
	parameter int LANES   = jts_pkg::JTS_LANES,
	parameter int EMB_LEN = jts_pkg::JTS_EMB_DEFAULT
) (
	input  wire logic                              sys_clk_in,
	input  wire logic                              rst_n_in,
	input  wire logic [jts_pkg::JTS_MODE_W-1:0]    interface_mode_select_in,
	input  wire logic                              scramble_enable_in,
	input  wire logic                              fec_enable_in,
	input  wire logic                              sysref_in,
	input  wire logic                              sync_n_in,
	input  wire logic [LANES*8-1:0]                adc_octets_in,
	input  wire logic [LANES*8-1:0]                ddc_octets_in,
	output logic      [LANES*8-1:0]                lane_octet_out,
	output logic      [LANES-1:0]                  lane_k_out,
	output logic      [1:0]                        lane_sh_out,
	output logic                                   block_start_out,
	output logic                                   lmfc_edge_out,
	output logic                                   enc64_out,
	output logic                                   fec_active_out,
	output jts_pkg::jts_decim_e                    decim_out,
	output logic      [jts_pkg::JTS_LANE_CNT_W-1:0] lanes_out,
	output logic                                   data_valid_out
);

	typedef enum logic [1:0] {
		LINK_IDLE,
		LINK_CGS,
		LINK_ILAS,
		LINK_DATA
	} jts_link_e;

	typedef struct packed {
		jts_link_e                 st;
		logic                      sref_s1;
		logic                      sref_s2;
		logic                      sref_s3;
		logic                      sync_prev;
		logic                      ilas_pend;
		logic [1:0]                ilas_mf;
		logic [7:0]                oct;
		logic [8:0]                frame;
		logic [2:0]                blk_oct;
		logic [4:0]                blk;
		logic [7:0]                emb;
		logic [LANES*8-1:0]        lane_oct;
		logic [LANES-1:0]          lane_k;
		logic [1:0]                sh;
		logic                      blk_start;
		logic                      lmfc_edge;
		logic                      enc64;
		logic                      fec;
		jts_decim_e                decim;
		logic [JTS_LANE_CNT_W-1:0] lanes;
		logic                      data_valid;
	} jts_tx_s;

	jts_tx_s            cur;
	jts_tx_s            next_cur;
	jts_mode_s          md;
	logic               sref_edge;
	logic               frame_last;
	logic               mf_last;
	logic               blk_last;
	logic               mb_last;
	logic               emb_last;
	logic               ext_last;
	logic               scr_on;
	logic [LANES*8-1:0] lane_oct_w;
	logic [LANES-1:0]   lane_k_w;

	assign md = jts_mode_lookup(interface_mode_select_in);
	// only the second and third stages feed the edge detector
	assign sref_edge  = cur.sref_s2 & ~cur.sref_s3;
	assign frame_last = cur.oct >= md.f - 8'h1;
	assign mf_last    = frame_last && (cur.frame >= md.k - 9'h1);
	assign blk_last   = cur.blk_oct == JTS_BLK_LAST;
	assign mb_last    = blk_last && (cur.blk == JTS_MB_LAST);
	assign emb_last   = mb_last && (cur.emb == 8'(EMB_LEN - 1));
	assign ext_last   = md.enc64 ? emb_last : mf_last;
	assign scr_on     = md.enc64 | scramble_enable_in;

	// every lane sees the same counters, so lanes stay mutually aligned
	for (genvar l = 0; l < LANES; l++) begin : g_lane
		logic [7:0] raw;
		logic [7:0] scr_o;
		logic [7:0] oct_v;
		logic       k_v;

		assign raw = (md.decim == JTS_DEC_BYPASS) ? adc_octets_in[l*8 +: 8]
			: ddc_octets_in[l*8 +: 8];

		jts_scrambler u_scr (
			.sys_clk_in (sys_clk_in),
			.rst_n_in   (rst_n_in),
			.data_in    (raw),
			.active_in  (scr_on && cur.st == LINK_DATA),
			.enc64_in   (md.enc64),
			.data_out   (scr_o)
		);

		always_comb begin
			oct_v = 8'h0;
			k_v = 1'b0;
			if (JTS_LANE_CNT_W'(l) < md.lanes) begin
				unique case (cur.st)
					LINK_IDLE: begin
						oct_v = 8'h0;
					end
					LINK_CGS: begin
						oct_v = JTS_K_COMMA;
						k_v = 1'b1;
					end
					LINK_ILAS: begin
						if (cur.oct == 8'h0 && cur.frame == 9'h0) begin
							oct_v = JTS_K_R;
							k_v = 1'b1;
						end else if (mf_last) begin
							oct_v = JTS_K_A;
							k_v = 1'b1;
						end else begin
							oct_v = cur.oct;
						end
					end
					LINK_DATA: begin
						oct_v = scr_o;
						// scrambled alignment monitoring characters
						if (!md.enc64 && scramble_enable_in && frame_last) begin
							k_v = (scr_o == JTS_K_F) || (mf_last && scr_o == JTS_K_A);
						end
					end
				endcase
			end
		end

		assign lane_oct_w[l*8 +: 8] = oct_v;
		assign lane_k_w[l] = k_v;
	end

	always_comb begin
		next_cur = cur;
		next_cur.sref_s1 = sysref_in;
		next_cur.sref_s2 = cur.sref_s1;
		next_cur.sref_s3 = cur.sref_s2;
		next_cur.sync_prev = sync_n_in;

		if (sref_edge) begin
			next_cur.oct = 8'h0;
			next_cur.frame = 9'h0;
			next_cur.blk_oct = 3'h0;
			next_cur.blk = 5'h0;
			next_cur.emb = 8'h0;
		end else begin
			next_cur.oct = frame_last ? 8'h0 : cur.oct + 8'h1;
			if (frame_last) begin
				next_cur.frame = mf_last ? 9'h0 : cur.frame + 9'h1;
			end
			next_cur.blk_oct = cur.blk_oct + 3'h1;
			if (blk_last) begin
				next_cur.blk = cur.blk + 5'h1;
			end
			if (mb_last) begin
				next_cur.emb = emb_last ? 8'h0 : cur.emb + 8'h1;
			end
		end

		unique case (cur.st)
			LINK_IDLE: begin
				if (md.enc64) begin
					next_cur.st = LINK_DATA;
				end else if (!sync_n_in) begin
					next_cur.st = LINK_CGS;
				end
			end
			LINK_CGS: begin
				if (md.enc64) begin
					next_cur.st = LINK_DATA;
				end else begin
					if (sync_n_in && !cur.sync_prev) begin
						next_cur.ilas_pend = 1'b1;
					end
					// alignment sequence starts on the next multiframe edge
					if (cur.ilas_pend && sync_n_in && ext_last) begin
						next_cur.st = LINK_ILAS;
						next_cur.ilas_mf = 2'h0;
						next_cur.ilas_pend = 1'b0;
					end
				end
			end
			LINK_ILAS: begin
				if (md.enc64) begin
					next_cur.st = LINK_DATA;
				end else if (!sync_n_in) begin
					next_cur.st = LINK_CGS;
				end else if (mf_last) begin
					next_cur.ilas_mf = cur.ilas_mf + 2'h1;
					if (cur.ilas_mf == JTS_ILAS_LAST) begin
						next_cur.st = LINK_DATA;
					end
				end
			end
			LINK_DATA: begin
				if (!md.enc64 && cur.enc64) begin
					next_cur.st = LINK_IDLE;
				end else if (!md.enc64 && !sync_n_in) begin
					next_cur.st = LINK_CGS;
				end
			end
		endcase
		if (cur.st != LINK_CGS) begin
			next_cur.ilas_pend = 1'b0;
		end

		next_cur.lane_oct = lane_oct_w;
		next_cur.lane_k = lane_k_w;
		// fixed data header: no command channel and no CRC3 use of it
		next_cur.blk_start = md.enc64 && cur.st == LINK_DATA
			&& cur.blk_oct == 3'h0;
		next_cur.sh = next_cur.blk_start ? JTS_SH_DATA : JTS_SH_NONE;
		next_cur.lmfc_edge = sref_edge | ext_last;
		next_cur.enc64 = md.enc64;
		next_cur.fec = md.enc64 & fec_enable_in;
		next_cur.decim = md.decim;
		next_cur.lanes = md.lanes;
		next_cur.data_valid = cur.st == LINK_DATA;
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign lane_octet_out  = cur.lane_oct;
	assign lane_k_out      = cur.lane_k;
	assign lane_sh_out     = cur.sh;
	assign block_start_out = cur.blk_start;
	assign lmfc_edge_out   = cur.lmfc_edge;
	assign enc64_out       = cur.enc64;
	assign fec_active_out  = cur.fec;
	assign decim_out       = cur.decim;
	assign lanes_out       = cur.lanes;
	assign data_valid_out  = cur.data_valid;

	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	AST_CGS_COMMA: assert property (
		cur.st == LINK_CGS |=> lane_k_out[0] && lane_octet_out[7:0] == JTS_K_COMMA)
		else $error("comma not sent during code group sync");
	AST_SYNC_IGNORED_64: assert property (
		md.enc64 && cur.st == LINK_DATA && !sync_n_in |=> cur.st == LINK_DATA)
		else $error("request line disturbed a 64b66b link");
	AST_SYNC_DROP: assert property (
		!md.enc64 && cur.enc64 == 1'b0 && cur.st inside {LINK_ILAS, LINK_DATA}
		&& !sync_n_in |=> cur.st == LINK_CGS)
		else $error("sync request did not restart the link");
	AST_SYSREF_RESET: assert property (
		$rose(cur.sref_s2) |=> cur.oct == 8'h0 && cur.frame == 9'h0
		&& cur.blk_oct == 3'h0 && cur.emb == 8'h0)
		else $error("sysref did not reset the multiframe counters");
	AST_SYSREF_LATENCY: assert property (
		$rose(sysref_in) |-> ##3 lmfc_edge_out)
		else $error("sysref edge not seen after two-stage capture");
	AST_ILAS_START: assert property (
		$rose(cur.st == LINK_ILAS) |=> lane_k_out[0]
		&& lane_octet_out[7:0] == JTS_K_R)
		else $error("alignment sequence did not open with R");
	AST_ILAS_LENGTH: assert property (
		cur.st == LINK_ILAS && sync_n_in && !md.enc64 && mf_last
		&& cur.ilas_mf == JTS_ILAS_LAST |=> cur.st == LINK_DATA)
		else $error("alignment sequence not four multiframes");
	AST_SH_HEADER: assert property (
		md.enc64 && cur.st == LINK_DATA && cur.blk_oct == 3'h0 && !sref_edge
		|=> block_start_out && lane_sh_out == JTS_SH_DATA ##1 !block_start_out)
		else $error("block header missing");
	AST_FEC_ONLY_64: assert property (
		fec_active_out |-> enc64_out && $past(fec_enable_in))
		else $error("fec active outside 64b66b");
	AST_LANE_MASK: assert property (
		cur.lanes == 5'h1 && $stable(interface_mode_select_in)
		|=> lane_octet_out[LANES*8-1:8] == '0)
		else $error("unused lane carried data");

	COV_CGS_TO_ILAS: cover property (
		cur.st == LINK_CGS ##1 cur.st == LINK_ILAS);
	COV_ILAS_TO_DATA: cover property (
		cur.st == LINK_ILAS ##1 cur.st == LINK_DATA);
	COV_SYSREF: cover property ($rose(cur.sref_s2));
	COV_BLOCK64: cover property (block_start_out && enc64_out);

endmodule : jts_tx

`default_nettype wire

// >>> jts_pkg.sv
/*
 * Shared constants, types and the interface-mode table of the JESD204C
 * transmit transport, scrambler and framing block.
 * Assumes one device clock for all logic and synchronous inputs.
 */
`default_nettype none

package jts_pkg;

	localparam int          JTS_LANES       = 16;
	localparam int          JTS_LANE_CNT_W  = 5;
	localparam int          JTS_EMB_DEFAULT = 1;
	localparam int          JTS_MODE_W      = 4;

	localparam logic [7:0]  JTS_K_COMMA     = 8'hbc;
	localparam logic [7:0]  JTS_K_R         = 8'h1c;
	localparam logic [7:0]  JTS_K_A         = 8'h7c;
	localparam logic [7:0]  JTS_K_F         = 8'hfc;

	localparam logic [1:0]  JTS_ILAS_LAST   = 2'h3;
	localparam logic [2:0]  JTS_BLK_LAST    = 3'h7;
	localparam logic [4:0]  JTS_MB_LAST     = 5'h1f;
	localparam logic [1:0]  JTS_SH_DATA     = 2'h1;
	localparam logic [1:0]  JTS_SH_NONE     = 2'h0;

	localparam int          JTS_SCR8_TAP_A  = 14;
	localparam int          JTS_SCR8_TAP_B  = 15;
	localparam int          JTS_SCR64_TAP_A = 39;
	localparam int          JTS_SCR64_TAP_B = 58;
	localparam logic [57:0] JTS_SCR_SEED    = 58'h0;

	typedef enum logic [2:0] {
		JTS_DEC_BYPASS,
		JTS_DEC_4,
		JTS_DEC_8,
		JTS_DEC_16,
		JTS_DEC_32
	} jts_decim_e;

	typedef struct packed {
		logic                      enc64;
		logic [JTS_LANE_CNT_W-1:0] lanes;
		logic [7:0]                f;
		logic [8:0]                k;
		jts_decim_e                decim;
	} jts_mode_s;

	// one selector fixes encoding, lane count, F, K and decimation together
	function automatic jts_mode_s jts_mode_lookup(
		input logic [JTS_MODE_W-1:0] sel
	);
		jts_mode_s m;
		m = '{1'b0, 5'h08, 8'h04, 9'h020, JTS_DEC_BYPASS};
		case (sel)
			4'h1: m = '{1'b0, 5'h10, 8'h02, 9'h040, JTS_DEC_BYPASS};
			4'h2: m = '{1'b0, 5'h04, 8'h08, 9'h010, JTS_DEC_4};
			4'h3: m = '{1'b0, 5'h02, 8'h08, 9'h010, JTS_DEC_8};
			4'h4: m = '{1'b1, 5'h08, 8'h08, 9'h004, JTS_DEC_BYPASS};
			4'h5: m = '{1'b1, 5'h10, 8'h04, 9'h008, JTS_DEC_BYPASS};
			4'h6: m = '{1'b1, 5'h02, 8'h08, 9'h004, JTS_DEC_16};
			4'h7: m = '{1'b1, 5'h01, 8'h08, 9'h004, JTS_DEC_32};
			default: m = m;
		endcase
		return m;
	endfunction : jts_mode_lookup

endpackage : jts_pkg

`default_nettype wire

// >>> jts_scrambler.sv
/*
 * One lane of the self-synchronous scrambler, eight bits per clock.
 * Assumes the caller holds active low while octets must pass unchanged.
 */
`default_nettype none

module jts_scrambler
	import jts_pkg::*;
(
	input  wire logic       sys_clk_in,
	input  wire logic       rst_n_in,
	input  wire logic [7:0] data_in,
	input  wire logic       active_in,
	input  wire logic       enc64_in,
	output logic      [7:0] data_out
);

	typedef struct packed {
		logic [JTS_SCR64_TAP_B-1:0] hist;
	} jts_scr_s;

	jts_scr_s                   cur;
	jts_scr_s                   next_cur;
	logic [JTS_SCR64_TAP_B-1:0] h;
	logic [7:0]                 scramble_enable;

	// msb first; history holds scrambled bits so the far end self-syncs
	always_comb begin
		next_cur = cur;
		h = cur.hist;
		scramble_enable = 8'h0;
		for (int i = 7; i >= 0; i--) begin
			if (enc64_in) begin
				scramble_enable[i] = data_in[i] ^ h[JTS_SCR64_TAP_A-1] ^ h[JTS_SCR64_TAP_B-1];
			end else begin
				scramble_enable[i] = data_in[i] ^ h[JTS_SCR8_TAP_A-1] ^ h[JTS_SCR8_TAP_B-1];
			end
			h = {h[JTS_SCR64_TAP_B-2:0], scramble_enable[i]};
		end
		if (active_in) begin
			next_cur.hist = h;
		end
		data_out = active_in ? scramble_enable : data_in;
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			cur.hist <= JTS_SCR_SEED;
		end else begin
			cur <= next_cur;
		end
	end

endmodule : jts_scrambler

`default_nettype wire

// >>> jts_rx_model.sv
/*
 * Receiver-side model: drives the sync request, descrambles lane 0.
 * Assumes transmitter outputs change on the rising device clock edge.
 */
`default_nettype none

module jts_rx_model
	import jts_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       ready_in,
	input  wire logic       hold_low_in,
	input  wire logic       scr_in,
	input  wire logic [7:0] octet_in,
	input  wire logic       k_in,
	input  wire logic       enc64_in,
	input  wire logic       lmfc_in,
	input  wire logic       valid_in,
	output logic            sync_n_out,
	output logic      [7:0] data_out,
	output logic            ok_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [57:0] hist;
	logic [7:0]  d;
	logic        aligned;
	int          commas;
	int          warm;

	initial sync_n_out = 1'b1;

	// request stays low until four commas and an lmfc edge were seen;
	// updated on the rising edge so it never races falling-edge stimulus
	always @(posedge clk_in) begin
		sync_n_out <= !(hold_low_in || (ready_in && !enc64_in && !aligned));
	end

	always @(posedge clk_in) begin
		if (!rst_n_in || !ready_in || hold_low_in) begin
			aligned <= 1'b0;
			commas = 0;
		end else begin
			commas = (k_in && octet_in == JTS_K_COMMA) ? commas + 1 : 0;
			if (commas >= 4 && lmfc_in)
				aligned <= 1'b1;
		end
	end

	// no seed is shared: the history fills from the line itself
	always @(posedge clk_in) begin
		if (!rst_n_in || !valid_in) begin
			warm = 0;
			ok_out <= 1'b0;
		end else begin
			for (int i = 7; i >= 0; i--) begin
				d[i] = octet_in[i] ^ ((scr_in || enc64_in) &&
					(enc64_in ? hist[38] ^ hist[57] : hist[13] ^ hist[14]));
				hist = {hist[56:0], octet_in[i]};
			end
			// a control octet may not match the history; wait it out
			warm = k_in ? 6 : warm + 1;
			data_out <= d;
			ok_out <= warm > 8;
		end
	end
endmodule : jts_rx_model

`default_nettype wire

// >>> jts_tx_tb.sv
/*
 * Self-checking bench of the transmit transport, scrambler and framing.
 * Assumes the receiver model watches lane 0; inputs change on falling edges.
 */
`default_nettype none

module jts_tx_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import jts_pkg::*;

	logic         sys_clk_in = 1'b0;
	logic         rst_n_in = 1'b0;
	logic [3:0]   interface_mode_select_in = 4'h0;
	logic         scramble_enable_in = 1'b0;
	logic         fec_enable_in = 1'b0;
	logic         sysref_in = 1'b0;
	logic         sync_n_in;
	logic [127:0] adc_octets_in = {16{8'h5a}};
	logic [127:0] ddc_octets_in = {16{8'ha5}};
	logic [127:0] lane_octet_out;
	logic [15:0]  lane_k_out;
	logic [1:0]   lane_sh_out;
	logic         block_start_out, lmfc_edge_out, enc64_out;
	logic         fec_active_out, data_valid_out;
	jts_decim_e   decim_out;
	logic [4:0]   lanes_out;
	logic         rx_ready = 1'b0;
	logic         rx_hold = 1'b0;
	logic [7:0]   rx_data;
	logic         rx_ok;
	int           errors = 0;
	int           check_count = 0;
	int           exp_l[8] = '{8, 16, 4, 2, 8, 16, 2, 1};
	int           exp_f[8] = '{4, 2, 8, 8, 8, 4, 8, 8};
	int           exp_k[8] = '{32, 64, 16, 16, 4, 8, 4, 4};
	int           exp_d[8] = '{0, 0, 1, 2, 0, 0, 3, 4};

	jts_tx #(.LANES(16), .EMB_LEN(1)) jts_tx_inst (
		.sys_clk_in, .rst_n_in, .interface_mode_select_in,
		.scramble_enable_in, .fec_enable_in, .sysref_in, .sync_n_in,
		.adc_octets_in, .ddc_octets_in, .lane_octet_out, .lane_k_out,
		.lane_sh_out, .block_start_out, .lmfc_edge_out, .enc64_out,
		.fec_active_out, .decim_out, .lanes_out, .data_valid_out);
	jts_rx_model jts_rx_model_inst (
		.clk_in(sys_clk_in), .rst_n_in, .ready_in(rx_ready),
		.hold_low_in(rx_hold), .scr_in(scramble_enable_in),
		.octet_in(lane_octet_out[7:0]), .k_in(lane_k_out[0]),
		.enc64_in(enc64_out), .lmfc_in(lmfc_edge_out),
		.valid_in(data_valid_out), .sync_n_out(sync_n_in),
		.data_out(rx_data), .ok_out(rx_ok));

	always #20 sys_clk_in = ~sys_clk_in;

	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic complete_run();
		$display("errors %0d comparisons %0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run

	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk_in);
	endtask : tick

	task automatic wait_k(input logic [7:0] oct, input int n, output logic f);
		int i;
		for (i = 0; i < n && !(lane_k_out[0] === 1'b1 &&
			lane_octet_out[7:0] === oct); i++)
			tick(1);
		f = i < n;
	endtask : wait_k

	task automatic next_lmfc(output int g);
		g = 0;
		do begin
			tick(1);
			g++;
		end while (lmfc_edge_out !== 1'b1 && g < 400);
	endtask : next_lmfc

	task automatic t_modes();
		fec_enable_in = 1'b1;
		for (int i = 0; i < 9; i++) begin
			interface_mode_select_in = (i == 8) ? 4'h9 : 4'(i);
			tick(3);
			check(enc64_out, i > 3 && i < 8);
			check(lanes_out, exp_l[i % 8]);
			check(decim_out, exp_d[i % 8]);
			check(fec_active_out, i > 3 && i < 8);
		end
		fec_enable_in = 1'b0;
	endtask : t_modes

	task automatic t_link8(input int m, input logic scramble_enable);
		int fk, l, oks;
		logic f, moved;
		logic [7:0] src;
		logic [8:0] e;
		fk = exp_f[m] * exp_k[m];
		l = exp_l[m];
		src = exp_d[m] ? 8'ha5 : 8'h5a;
		interface_mode_select_in = 4'(m);
		scramble_enable_in = scramble_enable;
		rx_ready = 1'b0;
		tick(4);
		rx_ready = 1'b1;
		wait_k(JTS_K_COMMA, 20, f);
		check(f, 1'b1);
		check({lane_k_out[l-1], lane_octet_out[8*l-8 +: 8]}, 9'h1bc);
		if (l < 16)
			check({lane_k_out[l], lane_octet_out[8*l +: 8]}, 9'h0);
		wait_k(JTS_K_R, 1000, f);
		check(f, 1'b1);
		// alignment frames stay plain even with scrambling on
		for (int p = 0; p < 4 * fk; p++) begin
			e = (p % fk == 0) ? {1'b1, JTS_K_R} : (p % fk == fk - 1) ?
				{1'b1, JTS_K_A} : {1'b0, 8'(p % exp_f[m])};
			check({lane_k_out[0], lane_octet_out[7:0]}, e);
			tick(1);
		end
		moved = 1'b0;
		oks = 0;
		for (int n = 0; n < 40; n++) begin
			tick(1);
			moved |= data_valid_out && !lane_k_out[0] &&
				lane_octet_out[7:0] !== src;
			if (rx_ok) begin
				oks++;
				check(rx_data, src);
			end
		end
		check(moved, scramble_enable);
		check(oks > 10, 1'b1);
	endtask : t_link8

	task automatic t_resync();
		logic f;
		rx_hold = 1'b1;
		tick(2);
		rx_hold = 1'b0;
		wait_k(JTS_K_COMMA, 10, f);
		check(f, 1'b1);
		wait_k(JTS_K_R, 1000, f);
		check(f, 1'b1);
	endtask : t_resync

	task automatic t_sysref();
		int g;
		next_lmfc(g);
		sysref_in = 1'b1;
		tick(1);
		sysref_in = 1'b0;
		next_lmfc(g);
		check(g < 8, 1'b1);
		next_lmfc(g);
		next_lmfc(g);
		check(g, 128);
	endtask : t_sysref

	task automatic t_64();
		int g, starts;
		interface_mode_select_in = 4'h4;
		scramble_enable_in = 1'b0;
		// request line held low: 64b/66b must ignore it
		rx_hold = 1'b1;
		tick(20);
		check(data_valid_out, 1'b1);
		g = 0;
		starts = 0;
		for (int n = 0; n < 64; n++) begin
			if (block_start_out === 1'b1) begin
				if (starts > 0)
					check(g, 8);
				starts++;
				g = 0;
			end
			check(lane_sh_out, block_start_out ? JTS_SH_DATA : JTS_SH_NONE);
			if (rx_ok)
				check(rx_data, 8'h5a);
			g++;
			tick(1);
		end
		check(starts > 6 && rx_ok, 1'b1);
		rx_hold = 1'b0;
	endtask : t_64

	initial begin
		tick(3);
		check(lane_octet_out, 128'h0);
		check({lane_k_out, data_valid_out, lmfc_edge_out}, 18'h0);
		rst_n_in = 1'b1;
		t_modes();
		t_link8(0, 1'b0);
		t_sysref();
		t_resync();
		t_link8(0, 1'b1);
		t_link8(2, 1'b0);
		t_link8(1, 1'b1);
		t_64();
		t_link8(3, 1'b1);
		complete_run();
	end

	initial begin
		#800000;
		errors++;
		complete_run();
	end
endmodule : jts_tx_tb

`default_nettype wire
